// ### itw_pkg.sv
package itw_pkg;
  // Byte addresses of the registers on the Wishbone bus
  localparam logic [7:0] ADDR_COUNT_CTL = 8'hec;
  localparam logic [7:0] ADDR_WDT_LIMIT = 8'hf0;
  localparam logic [7:0] ADDR_FLAGS = 8'hf4;

  // Clock control register fields
  localparam int CTL_SRC_LSB = 0;
  localparam int CTL_SRC_W = 3;
  localparam int CTL_ICLR_BIT = 3;
  localparam int CTL_WMODE_BIT = 4;
  localparam int CTL_RCSEL_BIT = 5;
  localparam logic [7:0] CTL_RESET = 8'h10;

  // Watchdog limit register fields
  localparam int WLIM_W = 7;
  localparam int WLIM_CLR_BIT = 7;
  localparam logic [6:0] WLIM_RESET = 7'h7f;

  // Flag register fields, write one to clear
  localparam int FLAG_IOVF_BIT = 0;
  localparam int FLAG_WMATCH_BIT = 1;

  // Prescaler: code 0 divides by 8, each code doubles, code 7 divides by 1024
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_BASE_MASK = 10'h007;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // Core clock rate; one machine cycle is one enabled clock
  localparam int CLK_HZ = 20000000;
  localparam int DATA_W = 32;
endpackage : itw_pkg

// ### itw_timer.sv
`timescale 1ns/1ns
`default_nettype none
module itw_timer #(
  parameter int ADR_W = 8
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic STOP_MODE,
  input wire logic RC_OSC,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [itw_pkg::DATA_W-1:0] WB_DAT_I,
  output logic [itw_pkg::DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic RC_MODE,
  output logic INTERVAL_FLAG,
  output logic WATCHDOG_FLAG,
  output logic WDT_RESET
);

  typedef struct packed {
    logic [itw_pkg::PRE_W-1:0] pre;
    logic [itw_pkg::CNT_W-1:0] cnt;
    logic [7:0] ctl;
    logic [itw_pkg::WLIM_W-1:0] wlim;
    logic wclr;
    logic [itw_pkg::WLIM_W-1:0] wcnt;
    logic iflag;
    logic wflag;
    logic wrst;
    logic ack;
    logic [7:0] rdat;
    logic rc_s1;
    logic rc_s2;
    logic rc_d;
    logic stop_d;
    logic rcm;
  } itw_state_t;

  itw_state_t s_reg;
  itw_state_t s_next;

  logic [itw_pkg::PRE_W-1:0] pre_mask;
  logic ptick;
  logic rc_edge;
  logic itick;
  logic wtick;
  logic wmatch;
  logic [itw_pkg::WLIM_W-1:0] wcnt_inc;
  logic bus_req;
  logic bus_wr;
  logic hit_ctl;
  logic hit_wlim;
  logic hit_flags;
  logic wr_iclr;
  logic wr_wclr;

  // Address decode; unmapped addresses still answer and read as zero
  assign hit_ctl = WB_ADR_I[7:2] == itw_pkg::ADDR_COUNT_CTL[7:2];
  assign hit_wlim = WB_ADR_I[7:2] == itw_pkg::ADDR_WDT_LIMIT[7:2];
  assign hit_flags = WB_ADR_I[7:2] == itw_pkg::ADDR_FLAGS[7:2];
  assign bus_req = WB_CYC_I && WB_STB_I && !s_reg.ack;
  // Writes land on the edge where the master sees ack, as classic cycles expect
  assign bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I && s_reg.ack && WB_SEL_I[0];
  assign wr_iclr = bus_wr && hit_ctl && WB_DAT_I[itw_pkg::CTL_ICLR_BIT];
  assign wr_wclr = bus_wr && hit_wlim && WB_DAT_I[itw_pkg::WLIM_CLR_BIT];

  // Prescaler taps: the mask widens by one bit per select code
  always_comb begin
    pre_mask = itw_pkg::PRE_BASE_MASK;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(s_reg.ctl[itw_pkg::CTL_SRC_LSB +: itw_pkg::CTL_SRC_W])) begin
        pre_mask = {pre_mask[itw_pkg::PRE_W-2:0], 1'b1};
      end
    end
  end

  assign ptick = (s_reg.pre & pre_mask) == pre_mask;
  assign rc_edge = s_reg.rc_s2 && !s_reg.rc_d;
  // In RC mode the interval timer steps on each RC period; otherwise the prescaler,
  // which halts with the main oscillator in plain stop mode
  assign itick = s_reg.rcm ? rc_edge : (!STOP_MODE && ptick);
  assign wtick = itick && (s_reg.cnt == itw_pkg::CNT_MAX) && !s_reg.ctl[itw_pkg::CTL_ICLR_BIT];
  assign wcnt_inc = s_reg.wcnt + 7'h01;
  assign wmatch = wtick && (wcnt_inc == s_reg.wlim) && !s_reg.wclr;

  always_comb begin
    s_next = s_reg;
    s_next.wrst = 1'b0;
    // RC oscillator pin: two flops before anything reads it
    s_next.rc_s1 = RC_OSC;
    s_next.rc_s2 = s_reg.rc_s1;
    s_next.rc_d = s_reg.rc_s2;
    s_next.stop_d = STOP_MODE;
    // RC mode is chosen at the moment stop is entered and lasts until stop ends
    if (!STOP_MODE) begin
      s_next.rcm = 1'b0;
    end else if (!s_reg.stop_d && s_reg.ctl[itw_pkg::CTL_RCSEL_BIT]) begin
      s_next.rcm = 1'b1;
    end
    // Prescaler runs only while the main oscillator does
    if (!STOP_MODE) begin
      s_next.pre = s_reg.pre + 10'h001;
    end
    // Interval counter: no stop control exists, only the clear bit
    if (s_reg.ctl[itw_pkg::CTL_ICLR_BIT]) begin
      s_next.ctl[itw_pkg::CTL_ICLR_BIT] = 1'b0;
    end
    if (itick) begin
      s_next.cnt = s_reg.cnt + 8'h01;
    end
    // Watchdog steps on interval overflow; held in stop unless RC clocked
    if (s_reg.wclr) begin
      s_next.wclr = 1'b0;
    end
    if (wmatch) begin
      s_next.wcnt = '0;
      if (s_reg.ctl[itw_pkg::CTL_WMODE_BIT]) begin
        s_next.wrst = 1'b1;
      end
    end else if (wtick) begin
      s_next.wcnt = wcnt_inc;
    end
    // Flags: hardware set beats a software clear in the same cycle
    if (bus_wr && hit_flags && WB_DAT_I[itw_pkg::FLAG_IOVF_BIT]) begin
      s_next.iflag = 1'b0;
    end
    if (bus_wr && hit_flags && WB_DAT_I[itw_pkg::FLAG_WMATCH_BIT]) begin
      s_next.wflag = 1'b0;
    end
    if (itick && s_reg.cnt == itw_pkg::CNT_MAX) begin
      s_next.iflag = 1'b1;
    end
    if (wmatch && !s_reg.ctl[itw_pkg::CTL_WMODE_BIT]) begin
      s_next.wflag = 1'b1;
    end
    // Register writes
    if (bus_wr && hit_ctl) begin
      s_next.ctl = WB_DAT_I[7:0];
    end
    if (bus_wr && hit_wlim) begin
      s_next.wlim = WB_DAT_I[itw_pkg::WLIM_W-1:0];
      s_next.wclr = WB_DAT_I[itw_pkg::WLIM_CLR_BIT];
    end
    // Clears override counting; interval clear also realigns the prescaler
    if (wr_iclr) begin
      s_next.cnt = '0;
      s_next.pre = '0;
    end
    if (wr_wclr) begin
      s_next.wcnt = '0;
    end
    // Bus answer: one cycle after the request, dropped the cycle after
    s_next.ack = bus_req;
    if (bus_req) begin
      unique case (1'b1)
        hit_ctl: s_next.rdat = s_reg.cnt;
        hit_wlim: s_next.rdat = {s_reg.wclr, s_reg.wlim};
        hit_flags: s_next.rdat = {6'h00, s_reg.wflag, s_reg.iflag};
        default: s_next.rdat = 8'h00;
      endcase
    end
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      s_reg <= '0;
      s_reg.ctl <= itw_pkg::CTL_RESET;
      s_reg.wlim <= itw_pkg::WLIM_RESET;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign WB_DAT_O = {24'h000000, s_reg.rdat};
  assign WB_ACK_O = s_reg.ack;
  assign RC_MODE = s_reg.rcm;
  assign INTERVAL_FLAG = s_reg.iflag;
  assign WATCHDOG_FLAG = s_reg.wflag;
  assign WDT_RESET = s_reg.wrst;

  sequence s_ctl_write_clear;
    wr_iclr;
  endsequence

  sequence s_clear_pulse;
    s_reg.ctl[itw_pkg::CTL_ICLR_BIT] ##1 !s_reg.ctl[itw_pkg::CTL_ICLR_BIT];
  endsequence

  property p_free_run;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (itick && !wr_iclr) |=> (s_reg.cnt == $past(s_reg.cnt) + 8'h01);
  endproperty
  a_free_run: assert property (p_free_run) else $error("Interval counter missed a step");

  property p_prescale;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (!STOP_MODE && !s_reg.rcm && s_reg.ctl[2:0] == 3'h0 && !wr_iclr) |->
      (itick == (s_reg.pre[2:0] == 3'h7));
  endproperty
  a_prescale: assert property (p_prescale) else $error("Divide by 8 tick wrong");

  property p_overflow_flag;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (itick && s_reg.cnt == 8'hff) |=> (s_reg.iflag && s_reg.cnt == 8'h00);
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("Overflow flag not set");

  property p_iclr;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      s_ctl_write_clear |=> (s_reg.cnt == 8'h00) ##0 s_clear_pulse;
  endproperty
  a_iclr: assert property (p_iclr) else $error("Interval clear bit misbehaved");

  property p_shared_read;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (bus_req && hit_ctl) |=> (WB_ACK_O && WB_DAT_O[7:0] == $past(s_reg.cnt)) ##1 !WB_ACK_O;
  endproperty
  a_shared_read: assert property (p_shared_read) else $error("Read of shared address wrong");

  property p_match_reset;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (wmatch && s_reg.ctl[4]) |=> (WDT_RESET && s_reg.wcnt == 7'h00) ##1 !WDT_RESET;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("Watchdog reset not pulsed");

  property p_match_flag;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (wmatch && !s_reg.ctl[4]) |=> (WATCHDOG_FLAG && !WDT_RESET);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("Watchdog flag not set");

  property p_wclr;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      wr_wclr |=> (s_reg.wcnt == 7'h00 && s_reg.wclr) ##1 !s_reg.wclr;
  endproperty
  a_wclr: assert property (p_wclr) else $error("Watchdog clear bit misbehaved");

  property p_stop_hold;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (STOP_MODE && !s_reg.rcm && !wr_wclr) |=> (s_reg.wcnt == $past(s_reg.wcnt));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("Watchdog moved in stop mode");

  property p_reset_mode;
    @(posedge CLOCK) disable iff (!RESETN)
      $rose(RESETN) |-> (s_reg.ctl[4] && s_reg.cnt == 8'h00 && s_reg.wcnt == 7'h00);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("Reset state wrong");

  // Further guards on RC entry and hold, watchdog stepping, bus pulse and flag clearing
  property p_rc_entry;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (STOP_MODE && !s_reg.stop_d && s_reg.ctl[itw_pkg::CTL_RCSEL_BIT]) |=> RC_MODE;
  endproperty
  a_rc_entry: assert property (p_rc_entry) else $error("RC mode not entered at stop");

  property p_rc_hold;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (s_reg.rcm && !rc_edge && !wr_iclr) |=> $stable(s_reg.cnt);
  endproperty
  a_rc_hold: assert property (p_rc_hold) else $error("Interval counter moved without an RC edge");

  property p_wdt_step;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (wtick && !wmatch && !wr_wclr) |=> (s_reg.wcnt == $past(s_reg.wcnt) + 7'h01);
  endproperty
  a_wdt_step: assert property (p_wdt_step) else $error("Watchdog missed an overflow step");

  property p_ack_pulse;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Bus acknowledge longer than one cycle");

  property p_flag_clear;
    @(posedge CLOCK) disable iff (!RESETN || !CE)
      (bus_wr && hit_flags && WB_DAT_I[itw_pkg::FLAG_IOVF_BIT] && !(itick && s_reg.cnt == itw_pkg::CNT_MAX))
      |=> !INTERVAL_FLAG;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Overflow flag not cleared by write");

endmodule : itw_timer
`default_nettype wire

// ### itw_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock = 1'b0, resetn = 1'b0, stop = 1'b0, rc = 1'b0, ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  logic ack, rc_mode, iflag, wflag, wrst;
  int fail_count = 0, checks_done = 0, ticks = 0, rst_seen = 0;

  // Clock enable is driven so that a frozen stretch can be checked
  itw_timer #(.ADR_W(8)) i_itw_timer (.CLOCK(clock), .RESETN(resetn), .CE(ce), .STOP_MODE(stop),
    .RC_OSC(rc), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RC_MODE(rc_mode), .INTERVAL_FLAG(iflag),
    .WATCHDOG_FLAG(wflag), .WDT_RESET(wrst));

  initial begin
    forever #25 clock = ~clock;
  end

  // Reset pulses are counted so a missed or doubled pulse shows up
  always @(posedge clock) begin
    ticks++;
    if (wrst === 1'b1) rst_seen++;
    if (ticks == 80000) begin
      fail_count++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clock);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = rdat;
    if (n >= 20) chk(32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // Ten clock cycles per edge pair keeps the synchroniser latency well inside
  task automatic rc_edges(input int n);
    repeat (n) begin
      repeat (5) @(posedge clock);
      rc <= 1'b1;
      repeat (5) @(posedge clock);
      rc <= 1'b0;
    end
  endtask : rc_edges

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    chk({iflag, wflag, wrst, rc_mode}, 32'h0);
    wb(1'b0, itw_pkg::ADDR_WDT_LIMIT, 32'h0, 4'h1);
    chk(q, 32'h7f);
    wb(1'b0, itw_pkg::ADDR_FLAGS, 32'h0, 4'h1);
    chk(q, 32'h0);
    wb(1'b0, 8'hf8, 32'h0, 4'h1);
    chk(q, 32'h0);
    // Byte lane 0 disabled: the write must not land
    wb(1'b1, itw_pkg::ADDR_WDT_LIMIT, 32'h81, 4'h0);
    wb(1'b0, itw_pkg::ADDR_WDT_LIMIT, 32'h0, 4'h1);
    chk(q, 32'h7f);
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h08, 4'h1);
    wb(1'b0, itw_pkg::ADDR_COUNT_CTL, 32'h0, 4'h1);
    chk(q, 32'h0);
    // Frozen stretch: 400 disabled cycles must not advance the count
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h08, 4'h1);
    ce <= 1'b0;
    idle(400);
    ce <= 1'b1;
    idle(28);
    wb(1'b0, itw_pkg::ADDR_COUNT_CTL, 32'h0, 4'h1);
    chk(q, 32'h3);
    // Mid-period sampling keeps the count clear of tick boundaries
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h08 | s, 4'h1);
      idle((8 << s) * 3 + (4 << s));
      wb(1'b0, itw_pkg::ADDR_COUNT_CTL, 32'h0, 4'h1);
      chk(q, 32'h3);
    end
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h08, 4'h1);
    wb(1'b1, itw_pkg::ADDR_FLAGS, 32'h3, 4'h1);
    idle(1990);
    chk(iflag, 32'h0);
    idle(150);
    chk(iflag, 32'h1);
    wb(1'b1, itw_pkg::ADDR_FLAGS, 32'h1, 4'h1);
    wb(1'b0, itw_pkg::ADDR_FLAGS, 32'h0, 4'h1);
    chk(q & 32'h1, 32'h0);
    // Interrupt mode, limit 3: three overflow periods
    wb(1'b1, itw_pkg::ADDR_WDT_LIMIT, 32'h83, 4'h1);
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h08, 4'h1);
    wb(1'b1, itw_pkg::ADDR_FLAGS, 32'h3, 4'h1);
    idle(3000);
    stop <= 1'b1;
    idle(8000);
    chk({wflag, rc_mode}, 32'h0);
    stop <= 1'b0;
    idle(2950);
    chk(wflag, 32'h0);
    idle(400);
    chk({wflag, rst_seen[0]}, 32'h2);
    // Reset mode, limit 2
    wb(1'b1, itw_pkg::ADDR_WDT_LIMIT, 32'h82, 4'h1);
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h18, 4'h1);
    idle(3900);
    chk(rst_seen, 0);
    idle(400);
    chk(rst_seen, 1);
    // Clearing at most one overflow apart keeps the count below the limit
    repeat (4) begin
      idle(1500);
      wb(1'b1, itw_pkg::ADDR_WDT_LIMIT, 32'h82, 4'h1);
    end
    chk(rst_seen, 1);
    // RC mode: interval and watchdog step on RC edges in stop
    wb(1'b1, itw_pkg::ADDR_COUNT_CTL, 32'h28, 4'h1);
    wb(1'b1, itw_pkg::ADDR_FLAGS, 32'h3, 4'h1);
    stop <= 1'b1;
    idle(3);
    chk(rc_mode, 32'h1);
    rc_edges(260);
    chk({iflag, wflag}, 32'h2);
    rc_edges(270);
    chk(wflag, 32'h1);
    stop <= 1'b0;
    idle(3);
    chk(rc_mode, 32'h0);
    test_done;
  end
endmodule : testbench
`default_nettype wire
